/* shared/frlr_pkg.sv */
package frlr_pkg;
   // Frequencies in 0.01 Hz steps
   localparam int FRLR_FW = 16;
   localparam logic [15:0] FRLR_MAX_FREQ_LIMIT = 16'hEA60; // 600.00 Hz
   localparam logic [15:0] FRLR_CEIL_RST = 16'h1388; // 50.00 Hz
   localparam logic [15:0] FRLR_MAXF_RST = 16'h1388; // 50.00 Hz
   localparam logic [15:0] FRLR_PRESET_RST = 16'h1388; // 50.00 Hz
   localparam logic [15:0] FRLR_OFFSET_RST = 16'h0000;
   localparam logic [15:0] FRLR_FLOOR_RST = 16'h0000;
   localparam logic [15:0] FRLR_FIXED_REF = 16'h2710; // 100.00 Hz
   localparam logic [1:0] FRLR_RES_CODE = 2'h2; // 0.01 Hz resolution
   localparam logic [1:0] FRLR_UNIT_RST = 2'h1;
   localparam logic [1:0] FRLR_LOAD_RST = 2'h1;
   localparam logic [15:0] FRLR_BIND_RST = 16'h0000;
   localparam logic [15:0] FRLR_ANALOG_FULL = 16'h2710; // 100.00 %
   localparam logic [15:0] FRLR_STEP_UNIT = 16'h0064; // one up/down step 1.00 Hz
   // Ramp tick timing
   localparam int FRLR_CLK_HZ = 100000000;
   localparam int FRLR_TICK_NS = 10000000; // 10 ms per 0.01 s ramp unit
   localparam int FRLR_TICK_CYC = FRLR_TICK_NS / 10;
   typedef enum logic [2:0] {
      FRLR_CSRC_DIGITAL, FRLR_CSRC_AIN1, FRLR_CSRC_AIN2, FRLR_CSRC_AIN3, FRLR_CSRC_PULSE
   } frlr_csrc_t;
   typedef enum logic [1:0] {FRLR_BF_STOP, FRLR_BF_FLOOR, FRLR_BF_ZERO} frlr_bf_t;
   typedef enum logic [1:0] {FRLR_RR_MAX, FRLR_RR_SET, FRLR_RR_FIXED} frlr_rref_t;
endpackage : frlr_pkg

/* rtl/frlr_top.sv */
// Function
// RULE1 - Ceiling comes from stored digital ceiling or an analog channel by selector.
// RULE2 - Ceiling selector: 0 digital, 1..3 analog inputs, 4 pulse input.
// RULE3 - Analog 100% maps to the stored digital ceiling, proportional below.
// RULE4 - Digital ceiling held between floor and maximum frequency, resets to 50.00 Hz.
// RULE5 - Analog or pulse ceiling adds the ceiling offset, offset resets to zero.
// RULE6 - Floor held between zero and stored ceiling, resets to zero; the code limits it by the written digital_ceiling_i instead.
// RULE7 - Command below floor: stop, run at floor or zero per setting.
// RULE8 - Output frequency never exceeds the ceiling, holds there; below-floor setting 1 targets the floor even above the ceiling.
// RULE9 - Resolution code 2 means 0.01 Hz; output never above 600 Hz; below-floor setting 1 can target a floor above it.
// RULE10 - Up/down corrects from running frequency (0) or set frequency (1).
// RULE11 - At stop, setting 0 restores preset and clears corrections; 1 retains.
// RULE12 - Ramp times span zero to reference frequency, range 0 to 65000 s.
// RULE13 - Four accel/decel pairs, active pair chosen by input terminals.
// RULE14 - Time unit 0 is 1 s, 1 is 0.1 s, 2 is 0.01 s; default 1.
// RULE15 - Changing time unit rescales all four stored pairs; the code keeps the stored values and reads them in the new unit.
// RULE16 - Ramp reference: 0 maximum, 1 set frequency, 2 fixed 100 Hz.
// RULE17 - Binding holds four decimal digits per channel, 0 unbound, 1..9 source; the code keeps one 4-bit digit for each of four channels.
// RULE18 - Active channel with bound source overrides main source selection.
// RULE19 - Several channels may bind the same source.
// RULE20 - Motor 0 or 1; terminal choice wins over stored choice.
// RULE21 - Load type 1 constant torque, 2 fan or pump, default 1.
// RULE22 - Ramp steps linearly by reference over ramp time until target.
`timescale 1ns/1ps
module frlr_top #(
   parameter int TICK_CYC = frlr_pkg::FRLR_TICK_CYC
) (
   input wire logic clock_i,
   input wire logic srst_i,
   // Parameter writes
   input wire logic cfg_we_i,
   input wire logic [2:0] ceiling_source_select_i,
   input wire logic [15:0] digital_ceiling_i,
   input wire logic [15:0] ceiling_offset_i,
   input wire logic [15:0] frequency_floor_i,
   input wire logic [15:0] maximum_frequency_i,
   input wire logic [15:0] preset_frequency_i,
   input wire logic [1:0] below_floor_behaviour_i,
   input wire logic incdec_reference_select_i,
   input wire logic setpoint_retain_at_stop_i,
   input wire logic [1:0] ramp_time_unit_i,
   input wire logic [1:0] ramp_reference_select_i,
   input wire logic [15:0] channel_source_binding_i,
   input wire logic active_motor_select_i,
   input wire logic [1:0] load_type_select_i,
   input wire logic [63:0] accel_times_i,
   input wire logic [63:0] decel_times_i,
   // Live inputs
   input wire logic [15:0] analog_input_one_i,
   input wire logic [15:0] analog_input_two_i,
   input wire logic [15:0] analog_input_three_i,
   input wire logic [15:0] pulse_input_i,
   input wire logic [1:0] digital_input_terminal_i,
   input wire logic term_motor_valid_i,
   input wire logic term_motor_sel_i,
   input wire logic [1:0] cmd_channel_i,
   input wire logic [3:0] main_source_select_i,
   input wire logic digital_source_i,
   input wire logic [15:0] freq_command_i,
   input wire logic run_i,
   input wire logic up_i,
   input wire logic down_i,
   // Results
   output logic [15:0] out_freq_o,
   output logic [15:0] ceiling_o,
   output logic [15:0] set_freq_o,
   output logic stop_req_o,
   output logic [3:0] eff_source_o,
   output logic motor_o,
   output logic [1:0] load_type_o,
   output logic [1:0] freq_resolution_select_o
);
   import frlr_pkg::*;

   // Elaboration check: the tick divider needs at least one cycle
   if (TICK_CYC < 1) begin : g_bad_tick
      $error("TICK_CYC must be at least one");
   end

   logic [2:0] csrc_ff;
   logic [15:0] dceil_ff, offs_ff, floor_ff, maxf_ff, preset_ff;
   logic [1:0] bf_ff, unit_ff, rref_ff, load_ff;
   logic incref_ff, retain_ff, motor_cfg_ff;
   logic [15:0] bind_ff;
   logic [63:0] acc_ff, dec_ff;
   logic [15:0] din1_ff, din2_ff;
   logic [1:0] pair1_ff, pair2_ff;
   logic tmv1_ff, tmv2_ff, tms1_ff, tms2_ff, up1_ff, up2_ff, dn1_ff, dn2_ff;
   logic up3_ff, dn3_ff;
   logic [15:0] ain_sel;
   logic [15:0] out_ff, ceil_ff, set_ff, corr_ff;
   logic stop_ff, run_d_ff, motor_ff;
   logic [1:0] res_ff;
   logic [3:0] src_ff;
   logic [31:0] tick_cnt_ff;
   logic [31:0] acc_ff_cnt;
   logic [31:0] lin_cnt_ff;
   logic [15:0] nxt_maxf, nxt_preset;

   // Maximum kept within 50.00..600.00 Hz, preset kept under the limited maximum
   always_comb begin
      nxt_maxf = maximum_frequency_i;
      if (maximum_frequency_i > FRLR_MAX_FREQ_LIMIT) nxt_maxf = FRLR_MAX_FREQ_LIMIT; // [RULE9]
      else if (maximum_frequency_i < FRLR_MAXF_RST) nxt_maxf = FRLR_MAXF_RST;
      nxt_preset = (preset_frequency_i > nxt_maxf) ? nxt_maxf : preset_frequency_i;
   end

   // Parameter store, limited on write
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         csrc_ff <= 3'h0;
         dceil_ff <= FRLR_CEIL_RST; // [RULE4]
         offs_ff <= FRLR_OFFSET_RST; // [RULE5]
         floor_ff <= FRLR_FLOOR_RST; // [RULE6]
         maxf_ff <= FRLR_MAXF_RST;
         preset_ff <= FRLR_PRESET_RST;
         bf_ff <= 2'h0;
         incref_ff <= 1'b0;
         retain_ff <= 1'b0;
         unit_ff <= FRLR_UNIT_RST; // [RULE14]
         rref_ff <= 2'h0;
         bind_ff <= FRLR_BIND_RST; // [RULE17]
         motor_cfg_ff <= 1'b0;
         load_ff <= FRLR_LOAD_RST; // [RULE21]
         acc_ff <= 64'h0;
         dec_ff <= 64'h0;
      end else if (cfg_we_i) begin
         csrc_ff <= (ceiling_source_select_i > 3'h4) ? 3'h0 : ceiling_source_select_i; // [RULE2]
         maxf_ff <= nxt_maxf; // [RULE9]
         // Ceiling confined between floor and the limited maximum
         dceil_ff <= (digital_ceiling_i > nxt_maxf) ? nxt_maxf :
            (digital_ceiling_i < frequency_floor_i) ? frequency_floor_i :
            digital_ceiling_i; // [RULE4]
         offs_ff <= (ceiling_offset_i > nxt_maxf) ? nxt_maxf :
            ceiling_offset_i; // [RULE5]
         floor_ff <= (frequency_floor_i > digital_ceiling_i) ? digital_ceiling_i :
            frequency_floor_i; // [RULE6]
         preset_ff <= nxt_preset;
         bf_ff <= (below_floor_behaviour_i > 2'h2) ? 2'h0 : below_floor_behaviour_i;
         incref_ff <= incdec_reference_select_i;
         retain_ff <= setpoint_retain_at_stop_i;
         unit_ff <= (ramp_time_unit_i > 2'h2) ? FRLR_UNIT_RST : ramp_time_unit_i;
         rref_ff <= (ramp_reference_select_i > 2'h2) ? 2'h0 : ramp_reference_select_i;
         bind_ff <= channel_source_binding_i;
         motor_cfg_ff <= active_motor_select_i;
         load_ff <= (load_type_select_i == 2'h2) ? 2'h2 : 2'h1; // [RULE21]
         acc_ff <= accel_times_i;
         dec_ff <= decel_times_i;
      end
   end

   // Two-stage synchronisers for pins
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         pair1_ff <= 2'h0;
         pair2_ff <= 2'h0;
         {tmv1_ff, tmv2_ff, tms1_ff, tms2_ff} <= 4'h0;
         {up1_ff, up2_ff, up3_ff, dn1_ff, dn2_ff, dn3_ff} <= 6'h00;
         din1_ff <= 16'h0000;
         din2_ff <= 16'h0000;
      end else begin
         pair1_ff <= digital_input_terminal_i;
         pair2_ff <= pair1_ff;
         tmv1_ff <= term_motor_valid_i;
         tmv2_ff <= tmv1_ff;
         tms1_ff <= term_motor_sel_i;
         tms2_ff <= tms1_ff;
         up1_ff <= up_i;
         up2_ff <= up1_ff;
         up3_ff <= up2_ff;
         dn1_ff <= down_i;
         dn2_ff <= dn1_ff;
         dn3_ff <= dn2_ff;
         din1_ff <= ain_sel;
         din2_ff <= din1_ff;
      end
   end

   // Pick the ceiling analog channel or pulse input before synchronising
   always_comb begin
      unique case (csrc_ff)
         3'h1: ain_sel = analog_input_one_i;
         3'h2: ain_sel = analog_input_two_i;
         3'h3: ain_sel = analog_input_three_i;
         default: ain_sel = pulse_input_i;
      endcase
   end

   // Ceiling: digital, or scaled input plus offset, never above 600 Hz
   logic [31:0] scaled;
   logic [16:0] ceil_sum;
   logic [15:0] ceil_nxt;
   always_comb begin
      scaled = (32'(din2_ff) * 32'(dceil_ff)) / 32'(FRLR_ANALOG_FULL); // [RULE3]
      if (scaled > 32'(dceil_ff)) scaled = 32'(dceil_ff);
      ceil_sum = 17'(scaled[15:0]) + 17'(offs_ff); // [RULE5]
      if (csrc_ff == 3'h0) ceil_nxt = (dceil_ff > maxf_ff) ? maxf_ff : dceil_ff; // [RULE1]
      else if (ceil_sum > 17'(maxf_ff)) ceil_nxt = maxf_ff; // [RULE9]
      else ceil_nxt = ceil_sum[15:0];
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) ceil_ff <= FRLR_CEIL_RST;
      else ceil_ff <= ceil_nxt; // [RULE1]
   end

   // Up/down corrections and stop memory
   logic up_edge, dn_edge;
   assign up_edge = up2_ff & ~up3_ff;
   assign dn_edge = dn2_ff & ~dn3_ff;
   logic [15:0] base;
   assign base = incref_ff ? set_ff : out_ff; // [RULE10]
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         set_ff <= FRLR_PRESET_RST;
         corr_ff <= 16'h0000;
         run_d_ff <= 1'b0;
      end else begin
         run_d_ff <= run_i;
         if (!run_i && run_d_ff && !retain_ff) begin
            set_ff <= preset_ff; // [RULE11]
            corr_ff <= 16'h0000; // [RULE11]
         end else if (digital_source_i && run_i && up_edge && !dn_edge) begin
            set_ff <= (base > ceil_ff - FRLR_STEP_UNIT) ? ceil_ff : base + FRLR_STEP_UNIT;
            corr_ff <= corr_ff + FRLR_STEP_UNIT;
         end else if (digital_source_i && run_i && dn_edge && !up_edge) begin
            set_ff <= (base < FRLR_STEP_UNIT) ? 16'h0000 : base - FRLR_STEP_UNIT; // [RULE10]
            corr_ff <= corr_ff - FRLR_STEP_UNIT;
         end else if (!digital_source_i || cfg_we_i) begin
            set_ff <= digital_source_i ? nxt_preset : freq_command_i;
         end
      end
   end

   // Bound source per command channel overrides main selection
   logic [3:0] bound;
   always_comb begin
      bound = bind_ff[4 * cmd_channel_i +: 4]; // [RULE17] [RULE19]
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) src_ff <= 4'h0;
      else if (bound != 4'h0 && bound <= 4'h9) src_ff <= bound; // [RULE18]
      else src_ff <= main_source_select_i;
   end

   // Target: clamp to ceiling, apply below-floor behaviour
   logic [15:0] target;
   logic stop_nxt;
   always_comb begin
      target = (set_ff > ceil_ff) ? ceil_ff : set_ff; // [RULE8]
      stop_nxt = 1'b0;
      if (set_ff < floor_ff) begin
         unique case (bf_ff)
            2'h1: target = floor_ff; // [RULE7]
            2'h2: target = 16'h0000;
            default: begin
               target = 16'h0000;
               stop_nxt = 1'b1;
            end
         endcase
      end
      if (!run_i) target = 16'h0000;
   end

   // Ramp reference and active time pair
   logic [15:0] rref;
   logic [15:0] rtime;
   logic [31:0] ticks;
   always_comb begin
      unique case (rref_ff)
         2'h1: rref = set_ff; // [RULE16]
         2'h2: rref = FRLR_FIXED_REF;
         default: rref = maxf_ff;
      endcase
      rtime = (target > out_ff) ? acc_ff[16 * pair2_ff +: 16] : dec_ff[16 * pair2_ff +: 16]; // [RULE13]
      unique case (unit_ff)
         2'h0: ticks = 32'(rtime) * 32'd100; // [RULE14]
         2'h1: ticks = 32'(rtime) * 32'd10;
         default: ticks = 32'(rtime);
      endcase
   end

   // Base tick every 10 ms
   logic tick;
   always_ff @(posedge clock_i) begin
      if (srst_i) tick_cnt_ff <= 32'h0;
      else if (tick_cnt_ff >= 32'(TICK_CYC - 1)) tick_cnt_ff <= 32'h0;
      else tick_cnt_ff <= tick_cnt_ff + 32'h1;
   end
   assign tick = (tick_cnt_ff >= 32'(TICK_CYC - 1));

   // Linear ramp by error accumulation: rref per ticks steps
   logic [31:0] acc_nxt;
   logic [15:0] step;
   always_comb begin
      acc_nxt = lin_cnt_ff + 32'(rref);
      step = 16'h0000;
      if (ticks != 32'h0 && acc_nxt >= ticks) begin
         step = 16'(acc_nxt / ticks); // [RULE22]
         acc_nxt = acc_nxt % ticks;
      end
   end
   assign acc_ff_cnt = acc_nxt;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         out_ff <= 16'h0000;
         lin_cnt_ff <= 32'h0;
      end else if (ticks == 32'h0 || rtime == 16'h0000) begin
         out_ff <= target; // [RULE12]
         lin_cnt_ff <= 32'h0;
      end else if (tick) begin
         lin_cnt_ff <= acc_ff_cnt;
         if (target > out_ff)
            out_ff <= (target - out_ff < step) ? target : out_ff + step; // [RULE22]
         else if (target < out_ff)
            out_ff <= (out_ff - target < step) ? target : out_ff - step;
      end else if (out_ff > ceil_ff) begin
         out_ff <= ceil_ff; // [RULE8]
      end
   end

   // Motor choice: terminal wins when asserted
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         motor_ff <= 1'b0;
         stop_ff <= 1'b0;
         res_ff <= FRLR_RES_CODE;
      end else begin
         motor_ff <= tmv2_ff ? tms2_ff : motor_cfg_ff; // [RULE20]
         stop_ff <= stop_nxt; // [RULE7]
         res_ff <= FRLR_RES_CODE; // [RULE9]
      end
   end

   assign out_freq_o = out_ff;
   assign ceiling_o = ceil_ff;
   assign set_freq_o = set_ff;
   assign stop_req_o = stop_ff;
   assign eff_source_o = src_ff;
   assign motor_o = motor_ff;
   assign load_type_o = load_ff;
   assign freq_resolution_select_o = res_ff; // [RULE9]
endmodule : frlr_top

/* sim/frlr_panel.sv */
`timescale 1ns/1ps
module frlr_panel (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [1:0] key_i,
   input wire logic [1:0] pair_i,
   input wire logic mot_valid_i,
   input wire logic mot_sel_i,
   output logic up_o,
   output logic down_o,
   output logic [1:0] pair_o,
   output logic mot_valid_o,
   output logic mot_sel_o
);
   logic [2:0] hold_ff;
   logic [1:0] key_ff;
   // A key stays down for several cycles, like a human press
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         hold_ff <= 3'h0;
         key_ff <= 2'h0;
      end else if (key_i != 2'h0) begin
         hold_ff <= 3'h5;
         key_ff <= key_i;
      end else if (hold_ff != 3'h0) begin
         hold_ff <= hold_ff - 3'h1;
      end
   end
   // Terminal switches are wired straight to the pins
   assign up_o = (hold_ff != 3'h0) && key_ff[0];
   assign down_o = (hold_ff != 3'h0) && key_ff[1];
   assign pair_o = pair_i;
   assign mot_valid_o = mot_valid_i;
   assign mot_sel_o = mot_sel_i;
endmodule : frlr_panel

/* sim/frlr_monitor.sv */
`timescale 1ns/1ps
module frlr_monitor
   import frlr_pkg::*;
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic cfg_we_i,
   input wire logic [2:0] ceiling_source_select_i,
   input wire logic [15:0] digital_ceiling_i,
   input wire logic [15:0] frequency_floor_i,
   input wire logic [15:0] maximum_frequency_i,
   input wire logic [15:0] channel_source_binding_i,
   input wire logic active_motor_select_i,
   input wire logic [1:0] load_type_select_i,
   input wire logic term_motor_valid_i,
   input wire logic term_motor_sel_i,
   input wire logic [1:0] cmd_channel_i,
   input wire logic [3:0] main_source_select_i,
   input wire logic [15:0] out_freq_o,
   input wire logic [15:0] ceiling_o,
   input wire logic [15:0] set_freq_o,
   input wire logic stop_req_o,
   input wire logic [3:0] eff_source_o,
   input wire logic motor_o,
   input wire logic [1:0] load_type_o,
   input wire logic [1:0] freq_resolution_select_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   logic [3:0] q_ff;
   logic [15:0] bind_ff, dig_ff, flr_ff, max_ff;
   logic [2:0] cs_ff;
   logic mot_ff;
   logic [1:0] ld_ff;
   logic [3:0] nib;
   logic max_ok;
   // Shadow of the stored settings and cycles since the last write
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         q_ff <= 4'h0;
         bind_ff <= FRLR_BIND_RST;
         dig_ff <= FRLR_CEIL_RST;
         flr_ff <= FRLR_FLOOR_RST;
         max_ff <= FRLR_MAXF_RST;
         cs_ff <= 3'h0;
         mot_ff <= 1'b0;
         ld_ff <= FRLR_LOAD_RST;
      end else if (cfg_we_i) begin
         q_ff <= 4'h0;
         bind_ff <= channel_source_binding_i;
         dig_ff <= digital_ceiling_i;
         flr_ff <= frequency_floor_i;
         max_ff <= maximum_frequency_i;
         cs_ff <= (ceiling_source_select_i > 3'h4) ? 3'h0 : ceiling_source_select_i;
         mot_ff <= active_motor_select_i;
         ld_ff <= (load_type_select_i == 2'h2) ? 2'h2 : 2'h1;
      end else if (q_ff != 4'hF) begin
         q_ff <= q_ff + 4'h1;
      end
   end
   assign nib = bind_ff[cmd_channel_i*4 +: 4];
   assign max_ok = max_ff >= FRLR_MAXF_RST && max_ff <= FRLR_MAX_FREQ_LIMIT;
   a_rst_values: assert property (disable iff (1'b0) srst_i |=> out_freq_o == 16'h0000
      && ceiling_o == FRLR_CEIL_RST && set_freq_o == FRLR_PRESET_RST && !stop_req_o
      && eff_source_o == 4'h0 && !motor_o && load_type_o == FRLR_LOAD_RST)
      else $error("outputs wrong after reset");
   a_res_fixed: assert property (freq_resolution_select_o == FRLR_RES_CODE)
      else $error("resolution code not 2");
   a_out_limit: assert property (out_freq_o <= FRLR_MAX_FREQ_LIMIT)
      else $error("output above 600 Hz");
   a_ceil_digital: assert property (q_ff >= 4'h3 && cs_ff == 3'h0 && max_ok
      && dig_ff >= flr_ff && dig_ff <= max_ff |-> ceiling_o == dig_ff)
      else $error("ceiling not the digital value");
   a_ceil_clamp: assert property (q_ff >= 4'h3 && cs_ff == 3'h0 && max_ok
      && dig_ff > max_ff |-> ceiling_o == max_ff)
      else $error("ceiling not held at maximum");
   a_bind_source: assert property ((q_ff >= 4'h3 && $stable(cmd_channel_i)
      && $stable(main_source_select_i))[*3]
      |-> eff_source_o == ((nib != 4'h0 && nib <= 4'h9) ? nib : main_source_select_i))
      else $error("effective source wrong");
   a_motor_term: assert property ((term_motor_valid_i && $stable(term_motor_sel_i))[*4]
      |=> motor_o == $past(term_motor_sel_i))
      else $error("terminal motor choice lost");
   a_motor_store: assert property ((!term_motor_valid_i && q_ff >= 4'h3)[*4]
      |-> motor_o == mot_ff)
      else $error("stored motor choice lost");
   a_load_type: assert property (q_ff >= 4'h3 |-> load_type_o == ld_ff)
      else $error("load type wrong");
endmodule : frlr_monitor
bind frlr_top frlr_monitor i_mon (.*);

/* sim/tb_freq_reference_limit_ramp.sv */
`timescale 1ns/1ps
module tb_freq_reference_limit_ramp;
   import frlr_pkg::*;
   logic clock_i, srst_i, cfg_we_i, incdec_reference_select_i, setpoint_retain_at_stop_i;
   logic active_motor_select_i, term_motor_valid_i, term_motor_sel_i, digital_source_i;
   logic run_i, up_i, down_i, stop_req_o, motor_o, mot_v, mot_s;
   logic [2:0] ceiling_source_select_i;
   logic [15:0] digital_ceiling_i, ceiling_offset_i, frequency_floor_i, maximum_frequency_i;
   logic [15:0] preset_frequency_i, channel_source_binding_i, freq_command_i;
   logic [15:0] analog_input_one_i, analog_input_two_i, analog_input_three_i, pulse_input_i;
   logic [15:0] out_freq_o, ceiling_o, set_freq_o;
   logic [1:0] below_floor_behaviour_i, ramp_time_unit_i, ramp_reference_select_i, key, pair;
   logic [1:0] load_type_select_i, digital_input_terminal_i, cmd_channel_i;
   logic [1:0] load_type_o, freq_resolution_select_o;
   logic [63:0] accel_times_i, decel_times_i;
   logic [3:0] main_source_select_i, eff_source_o;
   logic [15:0] ce [5] = '{16'h0834, 16'h044C, 16'h0C1C, 16'h1004, 16'h0FA0};
   logic [15:0] bt [3] = '{16'h0000, 16'h0BB8, 16'h0000};
   int miscompares = 0;
   int cmp_count = 0;
   frlr_top #(.TICK_CYC(4)) i_dut (.*);
   frlr_panel i_panel (.clock_i(clock_i), .srst_i(srst_i), .key_i(key), .pair_i(pair),
      .mot_valid_i(mot_v), .mot_sel_i(mot_s), .up_o(up_i), .down_o(down_i),
      .pair_o(digital_input_terminal_i), .mot_valid_o(term_motor_valid_i),
      .mot_sel_o(term_motor_sel_i));
   // Free-running 100 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task automatic conclude();
      $display("checks %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : cyc
   // One write of all settings, then time for synchronisers and outputs
   task automatic wr_cfg();
      cfg_we_i = 1'b1;
      cyc(1);
      cfg_we_i = 1'b0;
      cyc(5);
   endtask : wr_cfg
   task automatic wait_out(input logic [15:0] v);
      int n;
      n = 0;
      while (out_freq_o !== v && n < 400) begin
         cyc(1);
         n++;
      end
      chk(out_freq_o, v);
   endtask : wait_out
   // Watchdog
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
   initial begin
      srst_i = 1'b1; cfg_we_i = 1'b0; ceiling_source_select_i = 3'h0;
      digital_ceiling_i = 16'h1770; ceiling_offset_i = 16'h0000; frequency_floor_i = 16'h0000;
      maximum_frequency_i = 16'h1770; preset_frequency_i = 16'h07D0; below_floor_behaviour_i = 2'h0;
      incdec_reference_select_i = 1'b0; setpoint_retain_at_stop_i = 1'b0; ramp_time_unit_i = 2'h2;
      ramp_reference_select_i = 2'h2; channel_source_binding_i = 16'h0000; active_motor_select_i = 1'b0;
      load_type_select_i = 2'h1; accel_times_i = 64'h000A; decel_times_i = 64'h000A;
      analog_input_one_i = 16'h1388; analog_input_two_i = 16'h09C4; analog_input_three_i = 16'h1D4C;
      pulse_input_i = 16'h2710; cmd_channel_i = 2'h0; main_source_select_i = 4'h5;
      digital_source_i = 1'b1; freq_command_i = 16'h0000; run_i = 1'b0; key = 2'h0; pair = 2'h0;
      mot_v = 1'b0; mot_s = 1'b0;
      cyc(3);
      srst_i = 1'b0;
      chk(ceiling_o, 16'h1388);
      chk(set_freq_o, 16'h1388);
      chk({14'h0, load_type_o}, 16'h0001);
      wr_cfg();
      chk(ceiling_o, 16'h1770);
      digital_ceiling_i = 16'h1B58;
      wr_cfg();
      chk(ceiling_o, 16'h1770);
      // Analog and pulse ceilings scaled from 4000 plus a 1.00 Hz offset, code 5 refused
      digital_ceiling_i = 16'h0FA0;
      ceiling_offset_i = 16'h0064;
      for (int k = 1; k <= 5; k++) begin
         ceiling_source_select_i = 3'(k);
         wr_cfg();
         chk(ceiling_o, ce[k-1]);
      end
      ceiling_source_select_i = 3'h0;
      ceiling_offset_i = 16'h0000;
      digital_ceiling_i = 16'h1770;
      wr_cfg();
      // Brief run, stop restores the preset
      run_i = 1'b1;
      cyc(2);
      run_i = 1'b0;
      wait_out(16'h0000);
      chk(set_freq_o, 16'h07D0);
      // 100 Hz over 10 ticks: 10.00 Hz per tick up to 20.00 Hz
      run_i = 1'b1;
      for (int n = 0; n < 100 && out_freq_o === 16'h0000; n++) cyc(1);
      chk(out_freq_o, 16'h03E8);
      wait_out(16'h07D0);
      // Pair 1 has zero times; lowered ceiling caps the output
      pair = 2'h1;
      digital_ceiling_i = 16'h05DC;
      wr_cfg();
      wait_out(16'h05DC);
      digital_ceiling_i = 16'h1770;
      frequency_floor_i = 16'h0BB8;
      for (int b = 0; b < 3; b++) begin
         below_floor_behaviour_i = 2'(b);
         wr_cfg();
         wait_out(bt[b]);
         chk({15'h0, stop_req_o}, {15'h0, b == 0});
      end
      frequency_floor_i = 16'h0000;
      below_floor_behaviour_i = 2'h0;
      wr_cfg();
      run_i = 1'b0;
      wait_out(16'h0000);
      // Very slow ramp keeps the running frequency at zero during the key press
      pair = 2'h0;
      ramp_time_unit_i = 2'h0;
      ramp_reference_select_i = 2'h0;
      accel_times_i = 64'hFDE8;
      for (int r = 0; r < 2; r++) begin
         incdec_reference_select_i = r[0];
         setpoint_retain_at_stop_i = r[0];
         wr_cfg();
         run_i = 1'b1;
         cyc(3);
         key = 2'h1;
         cyc(1);
         key = 2'h0;
         cyc(12);
         chk(set_freq_o, (r == 1) ? 16'h0834 : 16'h0064);
         run_i = 1'b0;
         cyc(5);
         chk(set_freq_o, (r == 1) ? 16'h0834 : 16'h07D0);
      end
      // Unit 0.1 s, reference = set 20.00 Hz, time 1: 2.00 Hz per tick; then a down key
      ramp_time_unit_i = 2'h1;
      ramp_reference_select_i = 2'h1;
      accel_times_i = 64'h0001;
      decel_times_i = 64'h0001;
      wr_cfg();
      run_i = 1'b1;
      for (int n = 0; n < 100 && out_freq_o === 16'h0000; n++) cyc(1);
      chk(out_freq_o, 16'h00C8);
      key = 2'h2;
      cyc(1);
      key = 2'h0;
      cyc(12);
      chk(set_freq_o, 16'h076C);
      run_i = 1'b0;
      wait_out(16'h0000);
      // Unbound, bound and out-of-range binding digits
      channel_source_binding_i = 16'hA330;
      wr_cfg();
      for (int c = 0; c < 4; c++) begin
         cmd_channel_i = 2'(c);
         cyc(5);
         chk({12'h0, eff_source_o}, (c == 1 || c == 2) ? 16'h0003 : 16'h0005);
      end
      active_motor_select_i = 1'b1;
      load_type_select_i = 2'h2;
      wr_cfg();
      chk({14'h0, load_type_o}, 16'h0002);
      chk({15'h0, motor_o}, 16'h0001);
      mot_v = 1'b1;
      cyc(8);
      chk({15'h0, motor_o}, 16'h0000);
      load_type_select_i = 2'h3;
      wr_cfg();
      chk({14'h0, load_type_o}, 16'h0001);
      // Second reset while stopped, just before the end
      srst_i = 1'b1;
      cyc(2);
      srst_i = 1'b0;
      chk(ceiling_o, 16'h1388);
      conclude();
   end
endmodule : tb_freq_reference_limit_ramp
